/* File: led_dim_map.svh */
// register map, field positions, reset values and frame timing
//
// Notes on behaviour
// - dimming_enable 1 starts dimming; first on-edge within one dimming period.
// - paired_drive 0: every channel follows its own settings.
// - paired_drive 1: channels 2,4,6,8 copy outputs of channels 1,3,5,7.
// - logic_soft_reset 1 clears dimming logic and all registers but itself.
// - force-on bit n drives channel n+1 continuously on, except odd n with paired_drive 1; resets to 0.
// - force-on beats dimming: channel stays on whatever its duty.
// - force-on back to 0 resumes dimming at the programmed duty.
// - duty is 10 bits: low byte register plus bits 1-0 of high register.
// - duty N gives N dimming periods high; duty 0 keeps output low.
// - channels 2-8 use register pairs 04h-11h, same layout as channel 1.
// - channel output rises when the shared period counter becomes 1.
// - channel output falls when the counter passes the channel duty.
// - one period counter shared by all eight channels.
// - new duty adopted only when the period counter wraps to 0 or is held at 0.
// - serial port never auto-increments the register address.
`ifndef LED_DIM_MAP_SVH
`define LED_DIM_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DIMMING_CONTROL_OFS  6'h00
`define CHANNEL_FORCE_ON_OFS 6'h01
`define CH1_DUTY_LOW_OFS     6'h02
`define CH1_DUTY_HIGH_OFS    6'h03
`define LAST_REG_OFS         6'h11

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DIMMING_ENABLE_BIT   0
`define PAIRED_DRIVE_BIT     1
`define SOFT_RESET_BIT       7
`define DIMMING_CONTROL_RST  8'h00
`define CHANNEL_FORCE_ON_RST 8'h00
`define DUTY_RST             10'h000
`define DIMMING_CONTROL_HELD 8'h80

// ----------------------------------------
// serial frame: rw, spare, 6-bit address, 8-bit data, msb first
// ----------------------------------------
`define FRAME_BITS           5'h10
`define ADDR_DONE_COUNT      5'h08
`define FRAME_LAST_COUNT     5'h0f
`define PERIOD_LAST          10'h3ff

`endif

/* File: led_dim_pkg.sv */
// types shared by the dimming control block
package led_dim_pkg;

	typedef logic [9:0] duty_t;

	// one captured serial frame
	typedef struct packed {
		logic       read;
		logic       spare;
		logic [5:0] addr;
		logic [7:0] data;
	} serial_frame_s;

	// the three host-driven pins of the four-wire serial port
	typedef struct packed {
		logic clock;
		logic select_n;
		logic data;
	} serial_pins_s;

endpackage : led_dim_pkg

/* File: led_host_model.sv */
// host model driving the four-wire serial register port
`timescale 1ns/1ps
module led_host_model (
	// serial port
	output led_dim_pkg::serial_pins_s serial_out,
	input wire logic                  data_in,
	input wire logic                  data_oe_in
);
	import led_dim_pkg::*;
	initial serial_out = '{clock: 1'b0, select_n: 1'b1, data: 1'b0};
	// clock stands low between frames; read bits need the drive
	task frame(input logic rd, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] bits;
		bits = {rd, 1'b0, a, d};
		// own select, one frame per select
		serial_out.select_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_out.data = bits[i];
			#16 serial_out.clock = 1'b1;
			if (i < 8)
				q[i] = data_oe_in ? data_in : 1'bx;
			#16 serial_out.clock = 1'b0;
		end
		#16 serial_out.select_n = 1'b1;
		serial_out.data = ~bits[0];
		#120;
	endtask : frame
endmodule : led_host_model

/* File: led_pwm_dimming_control.sv */
// eight-channel led dimming control with four-wire serial register port
`timescale 1ns/1ps
`include "led_dim_map.svh"

module led_pwm_dimming_control (
	// system
	input  wire logic                       sys_clk_in,
	input  wire logic                       reset_n_in,
	// serial register port
	input  wire led_dim_pkg::serial_pins_s  serial_in,
	output logic                            serial_data_out,
	output logic                            serial_data_oe_out,
	// dimming
	input  wire logic                       dimming_clock_in,
	output logic [7:0]                      channel_output_on_out
);
	import led_dim_pkg::*;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0]    dimming_control;
	logic [7:0]    channel_force_on;
	duty_t         duty_written [8];
	duty_t         duty_active  [8];

	logic          dimming_enable;
	logic          paired_drive;
	logic          logic_soft_reset;

	assign dimming_enable   = dimming_control[`DIMMING_ENABLE_BIT];
	assign paired_drive     = dimming_control[`PAIRED_DRIVE_BIT];
	assign logic_soft_reset = dimming_control[`SOFT_RESET_BIT];

	// channel of a duty register pair, for reads and writes
	function automatic logic [2:0] duty_channel(input logic [5:0] addr);
		duty_channel = 3'(addr[4:1] - 4'h1);
	endfunction : duty_channel

	// read decode, used only by the serial side
	function automatic logic [7:0] reg_read(input logic [5:0] addr);
		logic [2:0] ch;
		ch = duty_channel(addr);
		reg_read = 8'h00;
		if (addr == `DIMMING_CONTROL_OFS) begin
			reg_read = dimming_control;
		end else if (addr == `CHANNEL_FORCE_ON_OFS) begin
			reg_read = channel_force_on;
		end else if (addr >= `CH1_DUTY_LOW_OFS && addr <= `LAST_REG_OFS) begin
			if (addr[0])
				reg_read = {6'h00, duty_written[ch][9:8]};
			else
				reg_read = duty_written[ch][7:0];
		end
	endfunction : reg_read

	// ----------------------------------------
	// serial clock domain
	// ----------------------------------------
	// select high holds the frame logic in reset, so nothing counts on
	// serial clock edges outside a frame
	logic          link_rst_n;
	logic [4:0]    bit_count;
	logic [14:0]   shift_in;
	serial_frame_s frame_word;
	logic          frame_toggle;
	logic [7:0]    read_shift;
	logic          read_drive;

	assign link_rst_n = reset_n_in & ~serial_in.select_n;

	always_ff @(posedge serial_in.clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_count <= 5'h00;
			shift_in  <= 15'h0000;
		end else if (bit_count != `FRAME_BITS) begin
			bit_count <= 5'(bit_count + 5'h01);
			shift_in  <= {shift_in[13:0], serial_in.data};
		end
	end

	// address taken from this frame only
	always_ff @(posedge serial_in.clock or negedge reset_n_in) begin
		if (!reset_n_in) begin
			frame_word   <= '0;
			frame_toggle <= 1'b0;
		end else if (!serial_in.select_n &&
		             bit_count == `FRAME_LAST_COUNT) begin
			frame_word   <= {shift_in, serial_in.data};
			frame_toggle <= ~frame_toggle;
		end
	end

	// readback: registers only change after the last bit of a write frame, so they are
	// quasi-static while shifted out here
	always_ff @(negedge serial_in.clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			read_shift <= 8'h00;
			read_drive <= 1'b0;
		end else if (bit_count == `ADDR_DONE_COUNT) begin
			read_shift <= reg_read(shift_in[5:0]);
			read_drive <= shift_in[7];
		end else if (bit_count > `ADDR_DONE_COUNT) begin
			read_shift <= {read_shift[6:0], 1'b0};
		end
	end

	assign serial_data_out    = read_shift[7];
	assign serial_data_oe_out = read_drive;

	// ----------------------------------------
	// crossings into the system domain
	// ----------------------------------------
	logic [2:0]    toggle_sync;
	logic [2:0]    dim_sync;
	logic          write_strobe;
	logic          dim_tick;

	// frame toggle: two flops, the third only for the edge compare
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			toggle_sync <= 3'h0;
		end else begin
			toggle_sync <= {toggle_sync[1:0], frame_toggle};
		end
	end

	// dimming pin: reset level is the idle low level, so no false
	// tick follows reset
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dim_sync <= 3'h0;
		end else begin
			dim_sync <= {dim_sync[1:0], dimming_clock_in};
		end
	end

	// frame_word is stable for many serial clocks after its toggle
	assign write_strobe = (toggle_sync[2] != toggle_sync[1]) &&
	                      !frame_word.read;
	assign dim_tick     = dim_sync[1] && !dim_sync[2];

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	logic          write_hit;
	logic [2:0]    write_ch;

	assign write_hit = write_strobe && frame_word.addr <= `LAST_REG_OFS;
	assign write_ch  = duty_channel(frame_word.addr);

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dimming_control <= `DIMMING_CONTROL_RST;
		end else if (write_hit &&
		             frame_word.addr == `DIMMING_CONTROL_OFS) begin
			if (frame_word.data[`SOFT_RESET_BIT])
				dimming_control <= `DIMMING_CONTROL_HELD;
			else
				dimming_control <= {1'b0, 5'h00, frame_word.data[1:0]};
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			channel_force_on <= `CHANNEL_FORCE_ON_RST;
		end else if (logic_soft_reset) begin
			channel_force_on <= `CHANNEL_FORCE_ON_RST;
		end else if (write_hit &&
		             frame_word.addr == `CHANNEL_FORCE_ON_OFS) begin
			channel_force_on <= frame_word.data;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_duty
			always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					duty_written[g] <= `DUTY_RST;
				end else if (logic_soft_reset) begin
					duty_written[g] <= `DUTY_RST;
				end else if (write_hit &&
				             frame_word.addr >= `CH1_DUTY_LOW_OFS &&
				             write_ch == 3'(g)) begin
					// low byte and two high bits
					if (frame_word.addr[0])
						duty_written[g][9:8] <= frame_word.data[1:0];
					else
						duty_written[g][7:0] <= frame_word.data;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// period counter and channel outputs
	// ----------------------------------------
	logic [9:0]    period_count;
	logic [9:0]    next_period_count;

	always_comb begin
		next_period_count = period_count;
		if (logic_soft_reset || !dimming_enable)
			next_period_count = 10'h000;
		else if (dim_tick)
			next_period_count = (period_count == `PERIOD_LAST) ?
			                    10'h000 : 10'(period_count + 10'h001);
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			period_count <= 10'h000;
		else
			period_count <= next_period_count;
	end

	generate
		for (g = 0; g < 8; g++) begin : g_active
			always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
				if (!reset_n_in)
					duty_active[g] <= `DUTY_RST;
				else if (next_period_count == 10'h000)
					duty_active[g] <= duty_written[g];
			end
		end
	endgenerate

	logic [7:0]    own_on;
	logic [7:0]    next_output_on;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			// high from count 1 to duty
			own_on[i] = dimming_enable &&
			            next_period_count != 10'h000 &&
			            next_period_count <= duty_active[i];
			own_on[i] = own_on[i] || channel_force_on[i];
		end
	end

	// pairs walked two at a time, so no index ever runs past seven
	always_comb begin
		for (int i = 0; i < 8; i += 2) begin
			next_output_on[i] = own_on[i];
			if (paired_drive) begin
				next_output_on[i + 1] = own_on[i];
			end else begin
				next_output_on[i + 1] = own_on[i + 1];
			end
		end
		if (logic_soft_reset) begin
			next_output_on = 8'h00;
		end
	end

	// output on the first tick after enable
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			channel_output_on_out <= 8'h00;
		else
			channel_output_on_out <= next_output_on;
	end

endmodule : led_pwm_dimming_control

/* File: led_pwm_dimming_control_chk.sv */
// port checks for the led dimming control
`timescale 1ns/1ps
module led_pwm_dimming_control_chk (
	// system
	input wire logic                      sys_clk_in,
	input wire logic                      reset_n_in,
	// serial port
	input wire led_dim_pkg::serial_pins_s serial_in,
	input wire logic                      serial_data_out,
	input wire logic                      serial_data_oe_out,
	// dimming
	input wire logic                      dimming_clock_in,
	input wire logic [7:0]                channel_output_on_out
);
	import led_dim_pkg::*;
	logic [3:0] quiet;
	logic [4:0] edges;
	logic       rd_bit;
	// ----
	// helpers
	// ----
	// quiet: cycles with no frame and no dimming edge
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			quiet <= 4'h0;
		else if (!serial_in.select_n || $changed(dimming_clock_in))
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
	end
	always_ff @(posedge serial_in.clock or posedge serial_in.select_n) begin
		if (serial_in.select_n)
			edges <= 5'h00;
		else if (edges != 5'h1f)
			edges <= edges + 5'h01;
	end
	always_ff @(posedge serial_in.clock)
		if (edges == 5'h00)
			rd_bit <= serial_in.data;
	// ----
	// assertions
	// ----
	a_reset_clear: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(reset_n_in) |-> channel_output_on_out == 8'h00)
		else $error("outputs set after reset");
	a_oe_idle_low: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		serial_in.select_n[*3] |-> !serial_data_oe_out)
		else $error("read drive without select");
	a_oe_release: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(serial_in.select_n) |-> ##[0:2] !serial_data_oe_out)
		else $error("read drive kept after frame");
	a_oe_in_frame: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(serial_data_oe_out) |-> !serial_in.select_n)
		else $error("read drive began outside frame");
	a_oe_holds: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		serial_data_oe_out && !serial_in.select_n
		|=> serial_data_oe_out || serial_in.select_n)
		else $error("read drive dropped in frame");
	a_out_quiet: assert property (
		@(posedge sys_clk_in) disable iff (!reset_n_in)
		quiet > 4'h8 |=> $stable(channel_output_on_out))
		else $error("output moved without cause");
	a_oe_early_off: assert property (
		@(negedge serial_in.clock) disable iff (serial_in.select_n)
		edges <= 5'h08 |-> !serial_data_oe_out)
		else $error("read drive before address end");
	a_oe_read_only: assert property (
		@(negedge serial_in.clock) disable iff (serial_in.select_n)
		edges > 5'h08 && edges <= 5'h10 |-> serial_data_oe_out == rd_bit)
		else $error("read drive not matching frame kind");
endmodule : led_pwm_dimming_control_chk

/* File: test_led_pwm_dimming_control.sv */
// self-checking bench for the led dimming control
`timescale 1ns/1ps
`include "led_dim_map.svh"
module test_led_pwm_dimming_control;
	import led_dim_pkg::*;
	logic         sys_clk_in;
	logic         reset_n_in;
	logic         dimming_clock_in;
	serial_pins_s pins;
	logic         sdo;
	logic         sdo_oe;
	logic [7:0]   chan_on;
	logic [7:0]   rd;
	logic [9:0]   duty [8];
	logic [10:0]  want [8];
	logic [10:0]  hi_cnt [8];
	int           num_errors;
	int           checks_done;
	led_pwm_dimming_control uut (
		.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
		.serial_in(pins), .serial_data_out(sdo),
		.serial_data_oe_out(sdo_oe), .dimming_clock_in(dimming_clock_in),
		.channel_output_on_out(chan_on));
	led_host_model host (
		.serial_out(pins), .data_in(sdo), .data_oe_in(sdo_oe));
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// ----
	// tasks
	// ----
	task chk(input string s, input logic [10:0] e, input logic [10:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task wr(input logic [5:0] a, input logic [7:0] d);
		host.frame(1'b0, a, d, rd);
	endtask : wr
	task rdchk(input logic [5:0] a, input logic [7:0] e);
		host.frame(1'b1, a, 8'h00, rd);
		chk("register", {3'h0, e}, {3'h0, rd});
	endtask : rdchk
	// n dimming ticks per call; outputs settle before each sampling
	task ticks(input int n);
		@(negedge sys_clk_in);
		for (int t = 0; t < n; t++) begin
			dimming_clock_in = 1'b1;
			repeat (4) @(negedge sys_clk_in);
			dimming_clock_in = 1'b0;
			repeat (4) @(negedge sys_clk_in);
			for (int c = 0; c < 8; c++)
				hi_cnt[c] += {10'h000, chan_on[c] === 1'b1};
		end
	endtask : ticks
	task expect_counts;
		for (int c = 0; c < 8; c++) begin
			chk("pulse width", want[c], hi_cnt[c]);
			hi_cnt[c] = 11'h000;
		end
	endtask : expect_counts
	task end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	// ----
	// tests
	// ----
	initial begin
		#1000000;
		num_errors++;
		end_sim;
	end
	initial begin
		reset_n_in = 1'b0;
		dimming_clock_in = 1'b0;
		num_errors = 0;
		checks_done = 0;
		hi_cnt = '{default: 11'h000};
		duty = '{10'h003, 10'h000, 10'h001, 10'h3ff,
			10'h002, 10'h005, 10'h155, 10'h3fe};
		repeat (16) @(negedge sys_clk_in);
		reset_n_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		for (int a = 0; a < 18; a++)
			rdchk(6'(a), 8'h00);
		wr(6'h03, 8'hff);
		rdchk(6'h03, 8'h03);
		for (int c = 0; c < 8; c++) begin
			wr(6'(2 * c + 2), duty[c][7:0]);
			wr(6'(2 * c + 3), {6'h00, duty[c][9:8]});
			want[c] = {1'b0, duty[c]};
		end
		rdchk(6'h09, 8'h03);
		wr(`DIMMING_CONTROL_OFS, 8'h01);
		ticks(1);
		chk("first tick", 11'h0fd, {3'h0, chan_on});
		ticks(1023);
		expect_counts;
		ticks(5);
		wr(6'h02, 8'h06);
		ticks(1019);
		expect_counts;
		want[0] = 11'h006;
		want[2] = 11'h400;
		want[7] = 11'h400;
		wr(6'h01, 8'h84);
		ticks(1024);
		expect_counts;
		wr(6'h01, 8'h00);
		want[2] = 11'h001;
		want[7] = 11'h3fe;
		ticks(1024);
		expect_counts;
		wr(6'h00, 8'h03);
		for (int c = 0; c < 8; c += 2)
			want[c + 1] = want[c];
		ticks(1024);
		expect_counts;
		ticks(2);
		wr(6'h00, 8'h80);
		chk("outputs", 11'h000, {3'h0, chan_on});
		rdchk(6'h00, 8'h80);
		rdchk(6'h02, 8'h00);
		wr(6'h01, 8'h04);
		rdchk(6'h01, 8'h00);
		chk("held outputs", 11'h000, {3'h0, chan_on});
		wr(6'h00, 8'h00);
		rdchk(6'h00, 8'h00);
		wr(6'h01, 8'h01);
		chk("force on", 11'h001, {3'h0, chan_on});
		wr(6'h01, 8'h00);
		wr(6'h02, 8'h01);
		ticks(3);
		wr(6'h00, 8'h01);
		ticks(1);
		chk("restart", 11'h001, {3'h0, chan_on});
		end_sim;
	end
endmodule : test_led_pwm_dimming_control
bind led_pwm_dimming_control led_pwm_dimming_control_chk chk (
	.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
	.serial_in(serial_in), .serial_data_out(serial_data_out),
	.serial_data_oe_out(serial_data_oe_out),
	.dimming_clock_in(dimming_clock_in),
	.channel_output_on_out(channel_output_on_out));
